/* File: rtl/ddr_latency_consts.svh */
/*
  Constants of the double-data-rate latency query table: byte offsets,
  byte values, row layout and opcodes.
  Assumes it is included by its bare name from design files.
*/
// Behaviour
// (R1) identifier byte 9Ah at offset 00h
// (R2) length byte 2Ah; next parameter follows
// (R3) five rows of eight; header "F","C"
// (R4) three-byte quad DDR read opcode EDh
// (R5) four-byte quad DDR read opcode EEh
// (R6) fast and dual DDR opcodes read FFh
// (R7) FFh everywhere means not supported
// (R8) code 11b, 50 MHz: 1 mode, 3 latency
// (R9) code 00b, 80 MHz: 1 mode, 6 latency
// (R10) codes 01b, 10b rows all FFh
// (R11) quad DDR read inserts configured code's cycles
`ifndef DDR_LATENCY_CONSTS_SVH
`define DDR_LATENCY_CONSTS_SVH

`define OFS_ID 8'h00
`define OFS_LEN 8'h01
`define OFS_ROWS 8'h02
`define OFS_ROW_LEN 8'h03
`define OFS_HDR_F 8'h04
`define OFS_HDR_C 8'h05
`define OFS_OP_QIO3 8'h0A
`define OFS_OP_QIO4 8'h0B
`define OFS_LAST 8'h2B

`define ROW_CODE11_BASE 8'h0C
`define ROW_CODE00_BASE 8'h14
`define ROW_CODE01_BASE 8'h1C
`define ROW_CODE10_BASE 8'h24
`define ROW_FREQ_OFS 8'h00
`define ROW_CODE_OFS 8'h01
`define ROW_QIO_MODE_OFS 8'h06
`define ROW_QIO_LAT_OFS 8'h07

`define VAL_ID 8'h9A
`define VAL_LEN 8'h2A
`define VAL_ROWS 8'h05
`define VAL_ROW_LEN 8'h08
`define VAL_HDR_F 8'h46
`define VAL_HDR_C 8'h43
`define VAL_OP_QIO3 8'hED
`define VAL_OP_QIO4 8'hEE
`define VAL_NONE 8'hFF

`define VAL_FREQ_CODE11 8'h32
`define VAL_CODE11 8'h03
`define VAL_MODE_CODE11 8'h01
`define VAL_LAT_CODE11 8'h03
`define VAL_FREQ_CODE00 8'h50
`define VAL_CODE00 8'h00
`define VAL_MODE_CODE00 8'h01
`define VAL_LAT_CODE00 8'h06

`define CODE_11 2'h3
`define CODE_00 2'h0
`define CODE_01 2'h1
`define CODE_10 2'h2
`define CODE_RESET 2'h0

`endif

/* File: rtl/ddr_latency_pkg.sv */
/*
  Types of the double-data-rate latency query table.
  Assumes ddr_latency_consts.svh holds the numbers.
*/
package ddr_latency_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_MODE = 4'b0010,
		ST_DUMMY = 4'b0100,
		ST_DATA = 4'b1000
	} rd_state_type;

	typedef enum logic [2:0] {
		FE_IDLE = 3'b001,
		FE_MODE = 3'b010,
		FE_LAT = 3'b100
	} fetch_state_type;

endpackage

/* File: rtl/ddr_query_rom.sv */
/*
  Query table storage: 44 bytes, two read ports, registered read data.
  Assumes addresses arrive on its own clock; one cycle of read latency.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr_latency_consts.svh"

module ddr_query_rom (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic en_i,
	input wire logic [7:0] addr_a_i,
	input wire logic [7:0] addr_b_i,
	output logic [7:0] data_a_o,
	output logic [7:0] data_b_o
);

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
	} rom_state_type;

	rom_state_type s_q;
	rom_state_type s_d;

	function automatic logic [7:0] table_byte(input logic [7:0] addr);
		case (addr)
			`OFS_ID: table_byte = `VAL_ID; // [R1]
			`OFS_LEN: table_byte = `VAL_LEN; // [R2]
			`OFS_ROWS: table_byte = `VAL_ROWS; // [R3]
			`OFS_ROW_LEN: table_byte = `VAL_ROW_LEN; // [R3]
			`OFS_HDR_F: table_byte = `VAL_HDR_F; // [R3]
			`OFS_HDR_C: table_byte = `VAL_HDR_C; // [R3]
			`OFS_OP_QIO3: table_byte = `VAL_OP_QIO3; // [R4]
			`OFS_OP_QIO4: table_byte = `VAL_OP_QIO4; // [R5]
			`ROW_CODE11_BASE + `ROW_FREQ_OFS: table_byte = `VAL_FREQ_CODE11; // [R8]
			`ROW_CODE11_BASE + `ROW_CODE_OFS: table_byte = `VAL_CODE11; // [R8]
			`ROW_CODE11_BASE + `ROW_QIO_MODE_OFS: table_byte = `VAL_MODE_CODE11; // [R8]
			`ROW_CODE11_BASE + `ROW_QIO_LAT_OFS: table_byte = `VAL_LAT_CODE11; // [R8]
			`ROW_CODE00_BASE + `ROW_FREQ_OFS: table_byte = `VAL_FREQ_CODE00; // [R9]
			`ROW_CODE00_BASE + `ROW_CODE_OFS: table_byte = `VAL_CODE00; // [R9]
			`ROW_CODE00_BASE + `ROW_QIO_MODE_OFS: table_byte = `VAL_MODE_CODE00; // [R9]
			`ROW_CODE00_BASE + `ROW_QIO_LAT_OFS: table_byte = `VAL_LAT_CODE00; // [R9]
			// fast/dual opcodes, rows 01b/10b, unused fields, beyond end
			default: table_byte = `VAL_NONE; // [R6] [R7] [R10]
		endcase
	endfunction

	always_comb
	begin
		s_d = s_q;
		if (en_i)
		begin
			s_d.a = table_byte(addr_a_i);
			s_d.b = table_byte(addr_b_i);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign data_a_o = s_q.a;
	assign data_b_o = s_q.b;

endmodule
`default_nettype wire

/* File: rtl/ddr_code_sync.sv */
/*
  Moves the configured latency code from the system clock to the link
  clock by a toggle request and acknowledge handshake.
  Assumes the source code is a register on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr_latency_consts.svh"

module ddr_code_sync (
	input wire logic clk_sys_i,
	input wire logic clk_link_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [1:0] code_i,
	output logic busy_o,
	output logic [1:0] code_o,
	output logic new_o
);

	typedef struct packed {
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic busy;
		logic [1:0] code;
	} src_state_type;

	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic ack_tgl;
		logic [1:0] code;
		logic fresh;
	} dst_state_type;

	src_state_type src_q;
	src_state_type src_d;
	dst_state_type dst_q;
	dst_state_type dst_d;

	// source code held stable while busy, so the wide word crosses safely
	always_comb
	begin
		src_d = src_q;
		src_d.ack_s1 = dst_q.ack_tgl;
		src_d.ack_s2 = src_q.ack_s1;
		if (ce_i)
		begin
			if (src_q.busy)
			begin
				if (src_q.ack_s2 == src_q.req_tgl)
					src_d.busy = 1'b0;
			end
			else if (code_i != src_q.code)
			begin
				src_d.code = code_i;
				src_d.req_tgl = ~src_q.req_tgl;
				src_d.busy = 1'b1;
			end
		end
	end

	always_comb
	begin
		dst_d = dst_q;
		dst_d.req_s1 = src_q.req_tgl;
		dst_d.req_s2 = dst_q.req_s1;
		dst_d.req_s3 = dst_q.req_s2;
		dst_d.fresh = 1'b0;
		if (dst_q.req_s2 != dst_q.req_s3)
		begin
			dst_d.code = src_q.code;
			dst_d.ack_tgl = dst_q.req_s2;
			dst_d.fresh = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			src_q <= '{req_tgl: 1'b0, ack_s1: 1'b0, ack_s2: 1'b0, busy: 1'b0, code: `CODE_RESET};
		else
			src_q <= src_d;
	end

	always_ff @(posedge clk_link_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			dst_q <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, ack_tgl: 1'b0,
				code: `CODE_RESET, fresh: 1'b0};
		else
			dst_q <= dst_d;
	end

	assign busy_o = src_q.busy;
	assign code_o = dst_q.code;
	assign new_o = dst_q.fresh;

endmodule
`default_nettype wire

/* File: rtl/ddr_latency_table.sv */
/*
  Double-data-rate latency query table with the quad I/O DDR read
  cycle sequencer it steers.
  Assumes the command decoder runs on the link clock and hands over
  query reads and DDR read starts on that clock; the latency code comes
  from a register on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ddr_latency_consts.svh"

module ddr_latency_table (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [1:0] latency_code_i,
	output logic code_busy_o,
	input wire logic clk_link_i,
	input wire logic frame_active_i,
	input wire logic query_rd_i,
	input wire logic [7:0] query_addr_i,
	output logic [7:0] query_data_o,
	output logic query_valid_o,
	input wire logic ddr_cmd_i,
	input wire logic [7:0] ddr_opcode_i,
	output logic mode_phase_o,
	output logic dummy_phase_o,
	output logic data_phase_o,
	output logic ddr_reject_o,
	output logic [1:0] code_applied_o
);

	typedef struct packed {
		logic busy;
	} sys_state_type;

	typedef struct packed {
		logic ce_s1;
		logic ce_s2;
		logic rd_pend;
		logic [7:0] qdata;
		logic qvalid;
		ddr_latency_pkg::fetch_state_type fetch;
		logic fetch_again;
		logic counts_ok;
		logic [1:0] code;
		logic [1:0] fetch_code;
		logic [7:0] mode_cnt;
		logic [7:0] lat_cnt;
		ddr_latency_pkg::rd_state_type state;
		logic [7:0] cnt;
		logic mode_ph;
		logic dummy_ph;
		logic data_ph;
		logic reject;
	} link_state_type;

	sys_state_type sys_q;
	sys_state_type sys_d;
	link_state_type lnk_q;
	link_state_type lnk_d;

	logic sync_busy;
	logic [1:0] sync_code;
	logic sync_new;
	logic [7:0] rom_a;
	logic [7:0] rom_b;
	logic [7:0] rom_addr_b;

	// row of the table that belongs to a latency code
	function automatic logic [7:0] row_base(input logic [1:0] code);
		case (code)
			`CODE_11: row_base = `ROW_CODE11_BASE; // [R8]
			`CODE_00: row_base = `ROW_CODE00_BASE; // [R9]
			`CODE_01: row_base = `ROW_CODE01_BASE; // [R10]
			`CODE_10: row_base = `ROW_CODE10_BASE; // [R10]
			default: row_base = `ROW_CODE00_BASE;
		endcase
	endfunction

	function automatic logic is_qio_ddr(input logic [7:0] op);
		is_qio_ddr = (op == `VAL_OP_QIO3) || (op == `VAL_OP_QIO4); // [R4] [R5]
	endfunction

	ddr_code_sync u_code_sync (
		.clk_sys_i(clk_sys_i),
		.clk_link_i(clk_link_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.code_i(latency_code_i),
		.busy_o(sync_busy),
		.code_o(sync_code),
		.new_o(sync_new)
	);

	ddr_query_rom u_rom (
		.clk_i(clk_link_i),
		.rst_n_i(rst_n_i),
		.en_i(lnk_q.ce_s2),
		.addr_a_i(query_addr_i),
		.addr_b_i(rom_addr_b),
		.data_a_o(rom_a),
		.data_b_o(rom_b)
	);

	always_comb
	begin
		sys_d = sys_q;
		if (ce_i)
			sys_d.busy = sync_busy;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sys_q <= '0;
		else
			sys_q <= sys_d;
	end

	// second read port walks the configured row: mode byte, then latency
	always_comb
	begin
		case (lnk_q.fetch)
			ddr_latency_pkg::FE_IDLE: rom_addr_b = 8'(row_base(lnk_q.code) + `ROW_QIO_MODE_OFS);
			ddr_latency_pkg::FE_MODE: rom_addr_b = 8'(row_base(lnk_q.fetch_code) + `ROW_QIO_LAT_OFS);
			ddr_latency_pkg::FE_LAT: rom_addr_b = 8'(row_base(lnk_q.fetch_code) + `ROW_QIO_LAT_OFS);
			default: rom_addr_b = 8'(row_base(lnk_q.code) + `ROW_QIO_MODE_OFS);
		endcase
	end

	always_comb
	begin
		lnk_d = lnk_q;
		lnk_d.ce_s1 = ce_i;
		lnk_d.ce_s2 = lnk_q.ce_s1;
		if (lnk_q.ce_s2)
		begin
			lnk_d.reject = 1'b0;
			lnk_d.qvalid = 1'b0;

			// query read: address this edge, rom data next, output after
			lnk_d.rd_pend = query_rd_i;
			if (lnk_q.rd_pend)
			begin
				lnk_d.qdata = rom_a; // [R1] [R2] [R3] [R7]
				lnk_d.qvalid = 1'b1;
			end

			// new code restarts the fetch; counts unusable until it lands
			if (sync_new)
			begin
				lnk_d.code = sync_code;
				lnk_d.fetch_again = 1'b1;
				lnk_d.counts_ok = 1'b0;
			end

			case (lnk_q.fetch)
				ddr_latency_pkg::FE_IDLE:
				begin
					if (lnk_q.fetch_again && !sync_new)
					begin
						lnk_d.fetch = ddr_latency_pkg::FE_MODE;
						lnk_d.fetch_code = lnk_q.code;
						lnk_d.fetch_again = 1'b0;
					end
				end
				ddr_latency_pkg::FE_MODE:
				begin
					lnk_d.mode_cnt = rom_b; // [R11]
					lnk_d.fetch = ddr_latency_pkg::FE_LAT;
				end
				ddr_latency_pkg::FE_LAT:
				begin
					lnk_d.lat_cnt = rom_b; // [R11]
					lnk_d.fetch = ddr_latency_pkg::FE_IDLE;
					lnk_d.counts_ok = !lnk_d.fetch_again;
				end
				default:
					lnk_d.fetch = ddr_latency_pkg::FE_IDLE;
			endcase

			// quad I/O DDR read: mode cycles, latency cycles, then data
			case (lnk_q.state)
				ddr_latency_pkg::ST_IDLE:
				begin
					if (ddr_cmd_i && frame_active_i)
					begin
						// FFh in a cycle field means the code has no DDR support
						if (!is_qio_ddr(ddr_opcode_i) || !lnk_q.counts_ok
							|| lnk_q.mode_cnt == `VAL_NONE
							|| lnk_q.lat_cnt == `VAL_NONE) // [R7] [R10]
							lnk_d.reject = 1'b1;
						else if (lnk_q.mode_cnt != 8'h00)
						begin
							lnk_d.state = ddr_latency_pkg::ST_MODE; // [R11]
							lnk_d.cnt = lnk_q.mode_cnt;
						end
						else if (lnk_q.lat_cnt != 8'h00)
						begin
							lnk_d.state = ddr_latency_pkg::ST_DUMMY;
							lnk_d.cnt = lnk_q.lat_cnt;
						end
						else
							lnk_d.state = ddr_latency_pkg::ST_DATA;
					end
				end
				ddr_latency_pkg::ST_MODE:
				begin
					lnk_d.cnt = 8'(lnk_q.cnt - 8'h01);
					if (lnk_q.cnt == 8'h01)
					begin
						if (lnk_q.lat_cnt != 8'h00)
						begin
							lnk_d.state = ddr_latency_pkg::ST_DUMMY; // [R8] [R9]
							lnk_d.cnt = lnk_q.lat_cnt;
						end
						else
							lnk_d.state = ddr_latency_pkg::ST_DATA;
					end
				end
				ddr_latency_pkg::ST_DUMMY:
				begin
					lnk_d.cnt = 8'(lnk_q.cnt - 8'h01);
					if (lnk_q.cnt == 8'h01)
						lnk_d.state = ddr_latency_pkg::ST_DATA; // [R8] [R9]
				end
				ddr_latency_pkg::ST_DATA:
					lnk_d.state = ddr_latency_pkg::ST_DATA;
				default:
					lnk_d.state = ddr_latency_pkg::ST_IDLE;
			endcase

			// end of frame always wins; clock may stop right after
			if (!frame_active_i)
			begin
				lnk_d.state = ddr_latency_pkg::ST_IDLE;
				lnk_d.cnt = 8'h00;
			end

			lnk_d.mode_ph = (lnk_d.state == ddr_latency_pkg::ST_MODE);
			lnk_d.dummy_ph = (lnk_d.state == ddr_latency_pkg::ST_DUMMY);
			lnk_d.data_ph = (lnk_d.state == ddr_latency_pkg::ST_DATA);
		end
	end

	always_ff @(posedge clk_link_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lnk_q <= '0;
			lnk_q.fetch <= ddr_latency_pkg::FE_IDLE;
			lnk_q.state <= ddr_latency_pkg::ST_IDLE;
			lnk_q.code <= `CODE_RESET;
			lnk_q.fetch_code <= `CODE_RESET;
			lnk_q.fetch_again <= 1'b1;
		end
		else
			lnk_q <= lnk_d;
	end

	assign code_busy_o = sys_q.busy;
	assign query_data_o = lnk_q.qdata;
	assign query_valid_o = lnk_q.qvalid;
	assign mode_phase_o = lnk_q.mode_ph;
	assign dummy_phase_o = lnk_q.dummy_ph;
	assign data_phase_o = lnk_q.data_ph;
	assign ddr_reject_o = lnk_q.reject;
	assign code_applied_o = lnk_q.code;

endmodule
`default_nettype wire

/* File: tb/ddr_latency_table_monitor.sv */
/*
 link-side checker of the latency query table.
 assumes ce_i high after reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_latency_table_monitor (
	input wire logic clk_link_i,
	input wire logic rst_n_i,
	input wire logic frame_active_i,
	input wire logic query_rd_i,
	input wire logic [7:0] query_addr_i,
	input wire logic [7:0] query_data_o,
	input wire logic query_valid_o,
	input wire logic ddr_cmd_i,
	input wire logic [7:0] ddr_opcode_i,
	input wire logic mode_phase_o,
	input wire logic dummy_phase_o,
	input wire logic data_phase_o,
	input wire logic ddr_reject_o,
	input wire logic [1:0] code_applied_o
);
	default clocking @(posedge clk_link_i);
	endclocking
	default disable iff (!rst_n_i);
	logic idle;
	logic bad_op;
	assign idle = !mode_phase_o && !dummy_phase_o && !data_phase_o;
	assign bad_op = ddr_opcode_i != 8'hED && ddr_opcode_i != 8'hEE;
	property byte_at(a, v);
		query_rd_i && query_addr_i == a |-> ##2 query_valid_o && query_data_o == v;
	endproperty
	AST_ID: assert property (byte_at(8'h00, 8'h9A))
		else $error("bad id byte");
	AST_LEN: assert property (byte_at(8'h01, 8'h2A))
		else $error("bad length byte");
	AST_HDR: assert property (byte_at(8'h04, 8'h46))
		else $error("bad header byte");
	AST_OP3: assert property (byte_at(8'h0A, 8'hED))
		else $error("bad 3-byte opcode");
	AST_OP4: assert property (byte_at(8'h0B, 8'hEE))
		else $error("bad 4-byte opcode");
	AST_ABSENT: assert property (query_rd_i && query_addr_i inside {[8'h06:8'h09],
		[8'h1C:8'h2B]} |-> ##2 query_data_o == 8'hFF)
		else $error("absent field not FFh");
	AST_MODE: assert property ($rose(mode_phase_o) |=> !mode_phase_o && dummy_phase_o)
		else $error("mode phase not one cycle");
	AST_LAT11: assert property ($rose(dummy_phase_o) && code_applied_o == 2'h3 |->
		dummy_phase_o[*3] ##1 !dummy_phase_o && data_phase_o)
		else $error("code 3 latency wrong");
	AST_LAT00: assert property ($rose(dummy_phase_o) && code_applied_o == 2'h0 |->
		dummy_phase_o[*6] ##1 !dummy_phase_o && data_phase_o)
		else $error("code 0 latency wrong");
	AST_REJ: assert property (ddr_cmd_i && frame_active_i && idle &&
		(bad_op || code_applied_o inside {2'h1, 2'h2}) |=> ddr_reject_o && !mode_phase_o)
		else $error("unsupported read not refused");
	cover property (query_valid_o);
	cover property ($rose(dummy_phase_o) && code_applied_o == 2'h3);
	cover property (ddr_reject_o);
endmodule
`default_nettype wire

/* File: tb/spi_host_model.sv */
/*
 host side of the link: clock runs inside frames and for two cycles after each frame ends.
 assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic clk_link_o,
	output logic frame_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic cmd_o,
	output logic [7:0] op_o,
	input wire logic [7:0] data_i,
	input wire logic valid_i,
	input wire logic mode_i,
	input wire logic dummy_i,
	input wire logic dphase_i,
	input wire logic reject_i
);
	logic run_q;
	initial
	begin
		run_q = 1'b0;
		clk_link_o = 1'b0;
		frame_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 8'h00;
		cmd_o = 1'b0;
		op_o = 8'h00;
	end
	always #6 clk_link_o = run_q ? ~clk_link_o : 1'b0;
	task automatic frame_on();
		frame_o = 1'b1;
		run_q = 1'b1;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_link_o);
	endtask
	task automatic frame_off();
		@(posedge clk_link_o);
		frame_o <= 1'b0;
		idle(2);
		run_q = 1'b0;
		#13;
	endtask
	task automatic query(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_link_o);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_link_o);
		rd_o <= 1'b0;
		addr_o <= ~a; // released: no stale address
		// valid stands one cycle only, so look just after it is launched
		idle(1);
		#1;
		d = data_i;
		v = valid_i;
	endtask
	task automatic ddr(input logic [7:0] op, output logic [7:0] m, output logic [7:0] l,
		output logic r, output logic dp);
		m = 8'h00;
		l = 8'h00;
		r = 1'b0;
		dp = 1'b0;
		frame_on();
		idle(2);
		cmd_o <= 1'b1;
		op_o <= op;
		@(posedge clk_link_o);
		cmd_o <= 1'b0;
		op_o <= ~op;
		// first look right after the taking edge: mode and reject last one cycle
		repeat (14)
		begin
			#1;
			m += {7'h00, mode_i};
			l += {7'h00, dummy_i};
			r |= reject_i;
			dp |= dphase_i;
			@(posedge clk_link_o);
		end
		frame_off();
	endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
 self-checking bench for the latency query table.
 assumes the host model drives the link side; ce stays high.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] TBL [0:27] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hED, 8'hEE, 8'h32, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01,
		8'h03, 8'h50, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'h06};
	logic clk_sys, rst_n, ce, busy, clk_link, frame, rd, cmd, valid, mode, dummy, dphase, reject;
	logic [1:0] code, applied;
	logic [7:0] addr, qdata, op;
	int err_total = 0;
	int checked = 0;
	always #12.5 clk_sys = ~clk_sys;
	ddr_latency_table i_dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_i(ce),
		.latency_code_i(code), .code_busy_o(busy), .clk_link_i(clk_link),
		.frame_active_i(frame), .query_rd_i(rd), .query_addr_i(addr), .query_data_o(qdata),
		.query_valid_o(valid), .ddr_cmd_i(cmd), .ddr_opcode_i(op), .mode_phase_o(mode),
		.dummy_phase_o(dummy), .data_phase_o(dphase), .ddr_reject_o(reject),
		.code_applied_o(applied));
	spi_host_model i_host (.clk_link_o(clk_link), .frame_o(frame), .rd_o(rd), .addr_o(addr),
		.cmd_o(cmd), .op_o(op), .data_i(qdata), .valid_i(valid), .mode_i(mode),
		.dummy_i(dummy), .dphase_i(dphase), .reject_i(reject));
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic t_query_map();
		logic [7:0] d;
		logic v;
		for (int a = 0; a < 45; a++)
		begin
			i_host.query(8'(a), d, v);
			chk8("query valid", 8'h01, {7'h00, v});
			chk8("query byte", (a < 28) ? TBL[a] : 8'hFF, d);
		end
		i_host.frame_off();
		$display("test query map done");
	endtask
	task automatic t_latency(input logic [1:0] c, input logic [7:0] m, input logic [7:0] l,
		input logic rej);
		logic [7:0] gm, gl;
		logic gr, gd;
		logic chg, seen;
		logic [7:0] ops [2] = '{8'hED, 8'hEE};
		i_host.frame_on();
		seen = 1'b0;
		@(posedge clk_sys);
		chg = (code != c);
		code <= c;
		for (int i = 0; i < 80 && (i < 4 || busy !== 1'b0); i++)
		begin
			@(posedge clk_sys);
			seen |= (busy === 1'b1);
		end
		#1;
		chk8("code busy", 8'h00, {7'h00, busy});
		chk8("code busy seen", {7'h00, chg}, {7'h00, seen});
		i_host.idle(4);
		i_host.frame_off();
		chk8("code applied", {6'h00, c}, {6'h00, applied});
		foreach (ops[k])
		begin
			i_host.ddr(ops[k], gm, gl, gr, gd);
			chk8("mode cycles", m, gm);
			chk8("latency cycles", l, gl);
			chk8("reject", {7'h00, rej}, {7'h00, gr});
			chk8("data phase", {7'h00, !rej}, {7'h00, gd});
		end
		$display("test latency code %0d done", c);
	endtask
	task automatic t_bad_op();
		logic [7:0] gm, gl;
		logic gr, gd;
		i_host.ddr(8'hFF, gm, gl, gr, gd);
		chk8("bad op reject", 8'h01, {7'h00, gr});
		chk8("bad op mode", 8'h00, gm);
		$display("test bad opcode done");
	endtask
	initial
	begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		code = 2'h0;
		#1;
		i_host.frame_on();
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		i_host.idle(3);
		t_query_map();
		t_latency(2'h0, 8'h01, 8'h06, 1'b0);
		t_bad_op();
		t_latency(2'h3, 8'h01, 8'h03, 1'b0);
		t_latency(2'h1, 8'h00, 8'h00, 1'b1);
		t_latency(2'h2, 8'h00, 8'h00, 1'b1);
		t_latency(2'h0, 8'h01, 8'h06, 1'b0);
		wrap_up();
	end
	// run needs under 10 us; over ten times that
	initial
	begin
		#100000;
		err_total++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule
bind ddr_latency_table ddr_latency_table_monitor i_mon (.*);
`default_nettype wire
